// *** design/rx_packet_decoder.sv ***
// receive data handler: demod gate, ook slicer, sync, node, length, crc
// assumes demodulated bits and rssi samples arrive synchronous to pclk
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rx_packet_decoder
	import rx_decoder_pkg::*;
#(
	parameter int FIFO_WORDS = 32
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// radio side
	input wire logic [7:0] rssi_code,
	input wire logic rssi_valid,
	input wire logic fsk_bit,
	input wire logic bit_valid,
	// outputs
	output logic demod_enable,
	output logic afc_enable,
	output logic fifo_threshold_irq,
	output logic data_out,
	output logic data_out_valid
);
	import rx_decoder_pkg::*;

	typedef enum logic [2:0] {
		ST_SYNC = 3'b000,
		ST_NODE = 3'b001,
		ST_LEN = 3'b011,
		ST_DATA = 3'b010,
		ST_CRC = 3'b110,
		ST_DONE = 3'b111
	} phase_type;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] slice;
		logic [31:0] sync;
		logic [31:0] pkt;
		logic [31:0] seed;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic [7:0] ref_lvl;
		logic [7:0] peak;
		logic demod;
		logic dbit;
		logic dvalid;
		logic half;
		logic first;
		logic [31:0] shreg;
		phase_type phase;
		logic [2:0] bitcnt;
		logic [7:0] byte_sr;
		logic [5:0] remain;
		logic [7:0] white;
		logic [15:0] crc;
		logic [15:0] crc_rx;
		logic crc_ok;
		logic crc_done;
		logic node_fail;
		logic [255:0] fifo;
		logic [5:0] wptr;
		logic [5:0] rptr;
		logic [5:0] count;
		logic irq;
		logic sync_hit;
	} state_type;

	state_type s_q, s_d;

	function automatic logic [5:0] ones32(input logic [31:0] v);
		logic [5:0] n;
		n = 6'h00;
		for (int i = 0; i < 32; i++) begin
			n = n + {5'h00, v[i]};
		end
		return n;
	endfunction

	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic b, input logic [15:0] poly);
		crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? poly : 16'h0000);
	endfunction

	logic [1:0] mode, dcfree, crcsel, nodesel, tol;
	logic [2:0] synclen;
	logic [7:0] fixed_slice_threshold, off_delta, node_id;
	logic [3:0] on_sel;
	logic [7:0] on_delta;
	logic [5:0] fifo_th, fix_len;
	logic [31:0] sync_mask;

	always_comb begin
		mode = s_q.ctrl[CTRL_MODE_LSB +: 2];
		dcfree = s_q.ctrl[CTRL_DCFREE_LSB +: 2];
		crcsel = s_q.ctrl[CTRL_CRC_LSB +: 2];
		nodesel = s_q.ctrl[CTRL_NODE_LSB +: 2];
		tol = s_q.ctrl[CTRL_TOL_LSB +: 2];
		synclen = s_q.ctrl[CTRL_SYNCLEN_LSB +: 3];
		fixed_slice_threshold = s_q.ctrl[CTRL_FTH_LSB +: 8];
		fix_len = s_q.ctrl[CTRL_LEN_LSB +: 6];
		off_delta = s_q.slice[7:0];
		on_sel = s_q.slice[11:8];
		on_delta = ON_DELTA_TABLE[on_sel * 8 +: 8];
		node_id = s_q.slice[23:16];
		fifo_th = s_q.slice[29:24];
		case (synclen)
			3'h1: sync_mask = 32'h000000FF;
			3'h2: sync_mask = 32'h0000FFFF;
			3'h3: sync_mask = 32'h00FFFFFF;
			3'h4: sync_mask = 32'hFFFFFFFF;
			default: sync_mask = 32'h00000000;
		endcase
	end

	logic in_bit, in_valid, cbit, cvalid, sync_match, byte_done;
	logic [7:0] new_byte, thr;
	logic [15:0] poly;
	logic [5:0] cap_len;

	always_comb begin
		s_d = s_q;
		s_d.ready = 1'b0;
		s_d.err = 1'b0;
		s_d.dvalid = 1'b0;
		in_bit = fsk_bit;
		in_valid = bit_valid;
		cbit = 1'b0;
		cvalid = 1'b0;
		byte_done = 1'b0;
		new_byte = 8'h00;
		poly = (crcsel == CRC_IBM) ? POLY_IBM : POLY_CCITT;
		cap_len = 6'h00;
		thr = s_q.ctrl[CTRL_PEAK_BIT] ? (s_q.peak >> 1) : fixed_slice_threshold;
		// rssi gating and ook slicing
		if (rssi_valid) begin
			if (s_q.ctrl[CTRL_PEAK_BIT]) begin
				s_d.peak = (rssi_code > s_q.peak) ? rssi_code
					: s_q.peak - {7'h00, |s_q.peak};
			end
			if (!s_q.demod) begin
				s_d.ref_lvl = (rssi_code < s_q.ref_lvl) ? rssi_code
					: s_q.ref_lvl;
				if ({1'b0, rssi_code} >= {1'b0, s_q.ref_lvl} +
					{1'b0, on_delta}) begin
					s_d.demod = 1'b1;
					s_d.ref_lvl = rssi_code;
				end
			end else begin
				s_d.ref_lvl = (rssi_code > s_q.ref_lvl) ? rssi_code
					: s_q.ref_lvl;
				if ({1'b0, rssi_code} + {1'b0, off_delta} <=
					{1'b0, s_q.ref_lvl} && off_delta != 8'hFF) begin
					s_d.demod = 1'b0;
					s_d.ref_lvl = rssi_code;
				end
			end
		end
		// ook slicing replaces the fsk bit stream when selected
		in_bit = s_q.slice[31] ? (rssi_code > thr) : fsk_bit;
		in_valid = s_q.slice[31] ? rssi_valid : bit_valid;
		if (mode == MODE_DIRECT) begin
			s_d.dbit = in_bit;
			s_d.dvalid = in_valid;
		end
		// sync search on raw line bits
		if (in_valid && mode != MODE_DIRECT) begin
			s_d.shreg = {s_q.shreg[30:0], in_bit};
		end
		sync_match = (synclen == 3'h0) ? 1'b1 :
			(ones32((s_d.shreg ^ s_q.sync) & sync_mask) <= {4'h0, tol});
		// line decoding
		if (in_valid && s_q.phase != ST_SYNC) begin
			if (dcfree == DC_MAN1 || dcfree == DC_MAN2) begin
				s_d.half = ~s_q.half;
				s_d.first = in_bit;
				if (s_q.half) begin
					cvalid = 1'b1;
					cbit = (dcfree == DC_MAN1) ? (!s_q.first && in_bit)
						: (s_q.first && !in_bit);
				end
			end else if (dcfree == DC_WHITE) begin
				cvalid = 1'b1;
				cbit = in_bit ^ s_q.white[0];
				s_d.white = {s_q.white[0] ^ s_q.white[4], s_q.white[7:1]};
			end else begin
				cvalid = 1'b1;
				cbit = in_bit;
			end
		end
		if (cvalid) begin
			s_d.byte_sr = {s_q.byte_sr[6:0], cbit};
			s_d.bitcnt = s_q.bitcnt + 3'h1;
			byte_done = (s_q.bitcnt == 3'h7);
			new_byte = {s_q.byte_sr[6:0], cbit};
			if (crcsel != CRC_NONE && (s_q.phase == ST_DATA
				|| s_q.phase == ST_LEN || s_q.phase == ST_NODE)) begin
				s_d.crc = crc_step(s_q.crc, cbit, poly);
			end
		end
		unique case (s_q.phase)
			ST_SYNC: begin
				if (in_valid && mode != MODE_DIRECT && sync_match) begin
					s_d.sync_hit = 1'b1;
					s_d.phase = (nodesel != NODE_OFF) ? ST_NODE
						: (s_q.ctrl[CTRL_VARLEN_BIT] ? ST_LEN : ST_DATA);
					s_d.remain = fix_len;
					s_d.white = s_q.seed[23:16];
					s_d.crc = s_q.seed[15:0];
					s_d.bitcnt = 3'h0;
					s_d.half = 1'b0;
					s_d.crc_done = 1'b0;
					s_d.node_fail = 1'b0;
					if (mode == MODE_PACKET && !s_q.ctrl[CTRL_VARLEN_BIT]
						&& nodesel == NODE_OFF && fix_len == 6'h00) begin
						s_d.phase = ST_DONE;
					end
				end
			end
			ST_NODE: if (byte_done) begin
				if (mode == MODE_PACKET && !((new_byte == node_id) ||
					(nodesel != NODE_ONLY && new_byte == 8'h00) ||
					(nodesel == NODE_BOTH && new_byte == 8'hFF))) begin
					s_d.node_fail = 1'b1;
					s_d.phase = ST_SYNC;
				end else begin
					s_d.phase = s_q.ctrl[CTRL_VARLEN_BIT] ? ST_LEN : ST_DATA;
				end
			end
			ST_LEN: if (byte_done) begin
				cap_len = (new_byte > {2'h0, FIFO_DEPTH}) ? FIFO_DEPTH
					: new_byte[5:0];
				s_d.remain = cap_len;
				// an empty payload goes straight to the crc or ends
				s_d.phase = (cap_len != 6'h00) ? ST_DATA
					: ((crcsel != CRC_NONE) ? ST_CRC : ST_DONE);
			end
			ST_DATA: if (byte_done) begin
				s_d.remain = s_q.remain - 6'h01;
				if (mode == MODE_PACKET && s_q.remain == 6'h01) begin
					s_d.phase = (crcsel != CRC_NONE) ? ST_CRC : ST_DONE;
				end
			end
			ST_CRC: if (byte_done) begin
				s_d.crc_rx = {s_q.crc_rx[7:0], new_byte};
				if (s_q.remain[0]) begin
					s_d.crc_ok = ({s_q.crc_rx[7:0], new_byte} == s_q.crc);
					s_d.crc_done = 1'b1;
					s_d.phase = ST_DONE;
				end
				s_d.remain = {5'h00, ~s_q.remain[0]};
			end
			ST_DONE: s_d.phase = ST_SYNC;
		endcase
		if (s_q.phase == ST_LEN && s_d.phase == ST_CRC) begin
			s_d.remain = 6'h00;
		end
		if (s_q.phase == ST_DATA && s_d.phase == ST_CRC) begin
			s_d.remain = 6'h00;
		end
		// fifo write and apb
		if (byte_done && s_q.phase == ST_DATA && s_q.count < FIFO_DEPTH) begin
			s_d.fifo[s_q.wptr[4:0] * 8 +: 8] = new_byte;
			s_d.wptr = s_q.wptr + 6'h01;
			s_d.count = s_q.count + 6'h01;
		end
		// setup cycle: decode, answer in the access cycle
		if (psel && !penable) begin
			s_d.ready = 1'b1;
			s_d.rdata = 32'h00000000;
			if (pwrite) begin
				unique case (paddr)
					ADDR_CTRL, ADDR_SLICE, ADDR_SYNC, ADDR_PKT, ADDR_SEED,
					ADDR_INPUT, ADDR_STATUS, ADDR_FIFO, ADDR_CRCVAL: ;
					default: s_d.err = 1'b1;
				endcase
			end else begin
				unique case (paddr)
					ADDR_CTRL: s_d.rdata = s_q.ctrl;
					ADDR_SLICE: s_d.rdata = s_q.slice;
					ADDR_SYNC: s_d.rdata = s_q.sync;
					ADDR_PKT: s_d.rdata = s_q.pkt;
					ADDR_SEED: s_d.rdata = s_q.seed;
					ADDR_INPUT: s_d.rdata = {16'h0000, s_q.peak, rssi_code};
					ADDR_STATUS: s_d.rdata = {16'h0000, s_q.count, 2'h0,
						s_q.node_fail, s_q.crc_ok, s_q.crc_done,
						s_q.sync_hit, s_q.demod, s_q.irq};
					ADDR_FIFO: begin
						s_d.rdata = {24'h000000, s_q.fifo[s_q.rptr[4:0] * 8 +: 8]};
						if (s_q.count != 6'h00) begin
							s_d.rptr = s_q.rptr + 6'h01;
							s_d.count = s_d.count - 6'h01;
						end
					end
					ADDR_CRCVAL: s_d.rdata = {s_q.crc_rx, s_q.crc};
					default: s_d.err = 1'b1;
				endcase
			end
		end
		// writes land at the completing edge of the access cycle
		if (psel && penable && pwrite && s_q.ready && !s_q.err) begin
			unique case (paddr)
				ADDR_CTRL: s_d.ctrl = pwdata;
				ADDR_SLICE: s_d.slice = pwdata;
				ADDR_SYNC: s_d.sync = pwdata;
				ADDR_PKT: s_d.pkt = pwdata;
				ADDR_SEED: s_d.seed = pwdata;
				default: ;
			endcase
		end
		s_d.irq = (s_d.count >= fifo_th) && (fifo_th != 6'h00);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.ctrl <= {2'h0, DATA_LEN_RST, FIXED_SLICE_THRESHOLD_RST, 1'b1, 1'b1,
				SYNCLEN_RST, 2'h0, NODE_OFF, CRC_NONE, DC_NONE, 1'b0,
				MODE_PACKET};
			s_q.slice <= {2'h0, FIFO_TH_RST, 8'h00, 4'h0, ON_SEL_RST,
				OFF_DELTA_RST};
			s_q.phase <= ST_SYNC;
			s_q.ref_lvl <= 8'hFF;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = s_q.ready;
	assign pslverr = s_q.err;
	assign demod_enable = s_q.demod;
	assign afc_enable = s_q.ctrl[CTRL_AFC_BIT];
	assign fifo_threshold_irq = s_q.irq;
	assign data_out = s_q.dbit;
	assign data_out_valid = s_q.dvalid;
endmodule
`default_nettype wire

// *** design/rx_decoder_pkg.sv ***
// constants for the receive packet decoder
// assumes one 200 MHz clock and APB register access
package rx_decoder_pkg;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_SLICE = 12'h004;
	localparam logic [11:0] ADDR_SYNC = 12'h008;
	localparam logic [11:0] ADDR_PKT = 12'h00C;
	localparam logic [11:0] ADDR_SEED = 12'h010;
	localparam logic [11:0] ADDR_INPUT = 12'h014;
	localparam logic [11:0] ADDR_STATUS = 12'h018;
	localparam logic [11:0] ADDR_FIFO = 12'h01C;
	localparam logic [11:0] ADDR_CRCVAL = 12'h020;
	// ctrl field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_VARLEN_BIT = 2;
	localparam int CTRL_DCFREE_LSB = 3;
	localparam int CTRL_CRC_LSB = 5;
	localparam int CTRL_NODE_LSB = 7;
	localparam int CTRL_TOL_LSB = 9;
	localparam int CTRL_SYNCLEN_LSB = 11;
	localparam int CTRL_AFC_BIT = 14;
	localparam int CTRL_PEAK_BIT = 15;
	localparam int CTRL_FTH_LSB = 16;
	localparam int CTRL_LEN_LSB = 24;
	// field encodings, polynomials and reset values
	localparam logic [1:0] MODE_DIRECT = 2'h0;
	localparam logic [1:0] MODE_BUFFER = 2'h1;
	localparam logic [1:0] MODE_PACKET = 2'h2;
	localparam logic [1:0] DC_NONE = 2'h0;
	localparam logic [1:0] DC_MAN1 = 2'h1;
	localparam logic [1:0] DC_MAN2 = 2'h2;
	localparam logic [1:0] DC_WHITE = 2'h3;
	localparam logic [1:0] CRC_NONE = 2'h0;
	localparam logic [1:0] CRC_CCITT = 2'h1;
	localparam logic [1:0] CRC_IBM = 2'h2;
	localparam logic [1:0] NODE_OFF = 2'h0;
	localparam logic [1:0] NODE_ONLY = 2'h1;
	localparam logic [1:0] NODE_ZERO = 2'h2;
	localparam logic [1:0] NODE_BOTH = 2'h3;
	localparam logic [15:0] POLY_CCITT = 16'h1021;
	localparam logic [15:0] POLY_IBM = 16'h8005;
	localparam logic [7:0] OFF_DELTA_RST = 8'hFF;
	localparam logic [3:0] ON_SEL_RST = 4'h7;
	localparam logic [7:0] FIXED_SLICE_THRESHOLD_RST = 8'h32;
	localparam logic [2:0] SYNCLEN_RST = 3'h3;
	localparam logic [5:0] DATA_LEN_RST = 6'h20;
	localparam logic [5:0] FIFO_TH_RST = 6'h20;
	localparam logic [5:0] FIFO_DEPTH = 6'h20;
	// selectable demod-on deltas
	localparam logic [127:0] ON_DELTA_TABLE = {
		8'h5A, 8'h42, 8'h36, 8'h2A, 8'h24, 8'h1E, 8'h1B, 8'h18,
		8'h15, 8'h12, 8'h0F, 8'h0C, 8'h09, 8'h06, 8'h03, 8'h00};
	localparam int XTAL_CLOCK_MHZ = 26;
	localparam int SYS_CLOCK_MHZ = 200;
endpackage

// *** testbench/rx_decoder_props.sv ***
// port assertions for the receive packet decoder
// assumes a bind onto rx_packet_decoder, single pclk domain
`timescale 1ns/1ps
`default_nettype none
module rx_decoder_props
	import rx_decoder_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// radio and status
	input wire logic rssi_valid,
	input wire logic demod_enable,
	input wire logic afc_enable
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_next: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	chk_ready_phase: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_map_ok: assert property (pready && paddr <= 12'h020
		&& paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("error on mapped address");
	chk_map_err: assert property (pready && paddr > 12'h020 |-> pslverr)
		else $error("no error on unmapped address");
	chk_afc_reset: assert property ($rose(presetn) |-> afc_enable)
		else $error("afc off after reset");
	chk_afc_cause: assert property ($changed(afc_enable)
		|-> $past(psel && penable && pwrite && paddr == ADDR_CTRL))
		else $error("afc changed without ctrl write");
	chk_demod_cause: assert property ($changed(demod_enable)
		|-> $past(rssi_valid) || $past(rssi_valid, 2) || $past(rssi_valid, 3))
		else $error("demod changed without rssi sample");
endmodule
`default_nettype wire

// *** testbench/radio_source.sv ***
// far-side radio model: rssi samples and demodulated bits
// assumes calls start right after a pclk edge
`timescale 1ns/1ps
`default_nettype none
module radio_source (
	// clock
	input wire logic pclk,
	// radio side
	output logic [7:0] rssi_code,
	output logic rssi_valid,
	output logic fsk_bit,
	output logic bit_valid
);
	initial begin
		rssi_code = 8'h00;
		rssi_valid = 1'b0;
		fsk_bit = 1'b0;
		bit_valid = 1'b0;
	end
	// idle lines show the inverse of the last value
	task automatic send_rssi(input logic [7:0] v);
		rssi_code <= v;
		rssi_valid <= 1'b1;
		@(posedge pclk);
		rssi_valid <= 1'b0;
		rssi_code <= ~v;
		repeat (3) @(posedge pclk);
	endtask
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			fsk_bit <= b[i];
			bit_valid <= 1'b1;
			@(posedge pclk);
			bit_valid <= 1'b0;
			fsk_bit <= ~b[i];
			repeat (2) @(posedge pclk);
		end
	endtask
endmodule
`default_nettype wire

// *** testbench/rx_packet_decoder_tb_top.sv ***
// self-checking bench for the receive packet decoder
// assumes the package, radio model and checker compile first
`timescale 1ns/1ps
`default_nettype none
module rx_packet_decoder_tb_top;
	import rx_decoder_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] rssi_code;
	logic rssi_valid, fsk_bit, bit_valid, err;
	logic demod_enable, afc_enable, fifo_threshold_irq;
	logic data_out, data_out_valid;
	logic got_q[$];
	int bad_count;
	int n_checks;
	localparam logic [31:0] CTRL_RST = {2'h0, DATA_LEN_RST, FIXED_SLICE_THRESHOLD_RST,
		2'h3, SYNCLEN_RST, 2'h0, NODE_OFF, CRC_NONE, DC_NONE, 1'b0,
		MODE_PACKET};
	localparam logic [31:0] SLICE_RST = {2'h0, FIFO_TH_RST, 12'h000,
		ON_SEL_RST, OFF_DELTA_RST};
	rx_packet_decoder rx_packet_decoder_i (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.rssi_code, .rssi_valid, .fsk_bit, .bit_valid, .demod_enable,
		.afc_enable, .fifo_threshold_irq, .data_out, .data_out_valid);
	radio_source radio_source_i (.pclk, .rssi_code, .rssi_valid,
		.fsk_bit, .bit_valid);
	initial pclk = 1'b0;
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		if (data_out_valid === 1'b1) begin
			got_q.push_back(data_out);
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		if (bad_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		check({31'h0, pready}, 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd = {29'h0, demod_enable, fifo_threshold_irq, afc_enable};
		check(rd, 32'h1);
		apb(1'b0, ADDR_CTRL, 32'h0);
		check(rd, CTRL_RST);
		apb(1'b0, ADDR_SLICE, 32'h0);
		check(rd, SLICE_RST);
	endtask
	// bounded wait on irq (sel 1) or demod (sel 0), then compare
	task automatic wait_lvl(input int sel, input logic exp);
		logic v;
		for (int i = 0; i < 200; i++) begin
			v = sel ? fifo_threshold_irq : demod_enable;
			if (v === exp) break;
			@(posedge pclk);
		end
		check({31'h0, v}, {31'h0, exp});
	endtask
	task automatic ook(input logic [31:0] c, input logic [31:0] s,
		input logic [3:0] exp, input logic [3:0] care);
		apb(1'b1, ADDR_CTRL, c);
		got_q.delete();
		for (int i = 3; i >= 0; i--) radio_source_i.send_rssi(s[8*i +: 8]);
		repeat (4) @(posedge pclk);
		check(got_q.size(), 32'h4);
		for (int i = 0; i < 4 && i < got_q.size(); i++) begin
			if (care[3-i]) check({31'h0, got_q[i]}, {31'h0, exp[3-i]});
		end
	endtask
	initial begin
		#100000;
		bad_count++;
		summarize();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		bad_count = 0;
		n_checks = 0;
		do_reset();
		apb(1'b0, 12'h100, 32'h0);
		check({31'h0, err}, 32'h1);
		apb(1'b1, ADDR_CTRL, 32'h20329802);
		@(posedge pclk);
		check({31'h0, afc_enable}, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h0132C802);
		apb(1'b1, ADDR_SLICE, 32'h010007FF);
		for (int i = 0; i < 3; i++) radio_source_i.send_rssi(8'h10);
		check({31'h0, demod_enable}, 32'h0);
		for (int i = 0; i < 3; i++) radio_source_i.send_rssi(8'h40);
		wait_lvl(0, 1'b1);
		apb(1'b1, ADDR_SYNC, 32'hD5D5D5D5);
		radio_source_i.send_byte(8'hD5);
		radio_source_i.send_byte(8'h3C);
		wait_lvl(1, 1'b1);
		apb(1'b0, ADDR_FIFO, 32'h0);
		check(rd & 32'hFF, 32'h3C);
		// variable length with node filter, then a foreign node
		apb(1'b1, ADDR_CTRL, 32'h20324886);
		apb(1'b1, ADDR_SLICE, 32'h025A07FF);
		radio_source_i.send_byte(8'hD5);
		radio_source_i.send_byte(8'h5A);
		radio_source_i.send_byte(8'h02);
		radio_source_i.send_byte(8'h11);
		radio_source_i.send_byte(8'h22);
		wait_lvl(1, 1'b1);
		apb(1'b0, ADDR_FIFO, 32'h0);
		check(rd, 32'h11);
		apb(1'b0, ADDR_FIFO, 32'h0);
		check(rd, 32'h22);
		radio_source_i.send_byte(8'hD5);
		radio_source_i.send_byte(8'h33);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check(rd & 32'h3F24, 32'h0024);
		apb(1'b1, ADDR_CTRL, 32'h20505800);
		apb(1'b1, ADDR_SLICE, 32'h200007FF);
		got_q.delete();
		radio_source_i.send_byte(8'hA5);
		repeat (4) @(posedge pclk);
		check(got_q.size(), 32'h8);
		for (int i = 0; i < 8 && i < got_q.size(); i++) begin
			check({31'h0, got_q[i]}, 32'(8'hA5 >> (7 - i)) & 32'h1);
		end
		apb(1'b1, ADDR_SLICE, 32'hA00007FF);
		ook(32'h20505800, 32'h30806010, 4'h6, 4'hF);
		ook(32'h2050D800, 32'h80602001, 4'h4, 4'h7);
		apb(1'b1, ADDR_CTRL, 32'h2032D802);
		apb(1'b1, ADDR_SLICE, 32'h20000714);
		for (int i = 0; i < 3; i++) radio_source_i.send_rssi(8'h60);
		wait_lvl(0, 1'b0);
		radio_source_i.send_rssi(8'h30);
		radio_source_i.send_rssi(8'h48);
		wait_lvl(0, 1'b1);
		for (int i = 0; i < 3; i++) radio_source_i.send_rssi(8'h30);
		wait_lvl(0, 1'b0);
		// mid-run reset must restore the defaults
		apb(1'b1, ADDR_CTRL, 32'h20329802);
		do_reset();
		summarize();
	end
endmodule
bind rx_packet_decoder rx_decoder_props rx_decoder_props_i (.pclk,
	.presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
	.rssi_valid, .demod_enable, .afc_enable);
`default_nettype wire
